/* File: design/flash_spc_pkg.sv */
/*
  flash_spc_pkg: register map, field positions, operation codes and timing
  constants for the flash self-programming controller.
  assumes: a single 50 MHz clock domain and a plain strobe register port.
*/
package flash_spc_pkg;
  localparam int unsigned ADDR_W          = 4;
  // register map (word addresses)
  localparam logic [3:0]  OFF_CTRL        = 4'h0;  // flash_operation_control
  localparam logic [3:0]  OFF_KEY         = 4'h1;  // flash_unlock_key
  localparam logic [3:0]  OFF_TABLE_PAGE  = 4'h2;
  localparam logic [3:0]  OFF_EFF_ADDR    = 4'h3;
  localparam logic [3:0]  OFF_TBL_LOW     = 4'h4;  // table_write_low / table_read_low
  localparam logic [3:0]  OFF_TBL_HIGH    = 4'h5;  // table_write_high / table_read_high
  localparam logic [3:0]  OFF_STATUS      = 4'h6;
  localparam logic [3:0]  OFF_TRIM        = 4'h7;
  // control fields
  localparam int unsigned CTL_GO          = 15;
  localparam int unsigned CTL_EN          = 14;
  localparam int unsigned CTL_ERR         = 13;
  localparam int unsigned CTL_ERASE       = 6;
  localparam logic [15:0] CTL_RESET       = 16'h0000;
  localparam logic [15:0] CTL_IMPL_MASK   = 16'hE04F;
  // table access write data: bit 16 byte mode, bit 17 byte select
  localparam int unsigned TBL_BYTE_MODE   = 16;
  localparam int unsigned TBL_BYTE_SEL    = 17;
  // unlock keys
  localparam logic [7:0]  KEY_FIRST       = 8'h55;
  localparam logic [7:0]  KEY_SECOND      = 8'hAA;
  // operation codes
  localparam logic [3:0]  OP_BULK         = 4'hF;
  localparam logic [3:0]  OP_RSVD_E       = 4'hE;
  localparam logic [3:0]  OP_GENSEG       = 4'hD;
  localparam logic [3:0]  OP_SECSEG       = 4'hC;
  localparam logic [3:0]  OP_RSVD_B       = 4'hB;
  localparam logic [3:0]  OP_WORD         = 4'h3;
  localparam logic [3:0]  OP_PAGE         = 4'h2;
  localparam logic [3:0]  OP_ROW          = 4'h1;
  localparam logic [3:0]  OP_CFG          = 4'h0;
  // array geometry
  localparam int unsigned ROW_INSTR       = 64;
  localparam int unsigned PAGE_ROWS       = 8;
  localparam int unsigned ROW_BYTES       = 192;
  localparam int unsigned PAGE_BYTES      = 1536;
  // timing: internal_fast_rc nominal rate, row write cycles
  localparam int unsigned FRC_KHZ         = 7370;
  localparam int unsigned MCLK_KHZ        = 50000;
  localparam int unsigned ROW_FRC_CYC     = 11064;
  localparam int unsigned TRIM_W          = 6;
  // flash array command codes
  typedef enum logic [2:0] {
    FCMD_NONE  = 3'h0,
    FCMD_BULK  = 3'h1,
    FCMD_SEG   = 3'h2,
    FCMD_PAGE  = 3'h3,
    FCMD_CFGE  = 3'h4,
    FCMD_WORD  = 3'h5,
    FCMD_ROW   = 3'h6,
    FCMD_CFGP  = 3'h7
  } fcmd_e;
endpackage

/* File: design/frc_tick_gen.sv */
/*
  frc_tick_gen: makes a one-cycle enable at the trimmed internal_fast_rc
  rate from the master clock by phase accumulation.
  assumes: trim is a signed code worth 1/256 of the step per count, stable during operations.
*/
`timescale 1ns/100ps
module frc_tick_gen
  import flash_spc_pkg::*;
#(
  parameter int unsigned ACC_W = 16
) (
  input  wire logic              i_mclk,
  input  wire logic              i_nrst,
  input  wire logic [TRIM_W-1:0] i_trim,
  output logic                   o_tick
);
  localparam logic [ACC_W-1:0] STEP = ACC_W'((longint'(FRC_KHZ) << ACC_W) / MCLK_KHZ);

  if (ACC_W < 12 || FRC_KHZ >= MCLK_KHZ) begin : g_bad_cfg
    $error("frc_tick_gen: bad configuration");
  end

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W:0]   sum;
  logic [ACC_W-1:0] step;

  // trim nudges step by 1/256 per count; sign-extended code
  always_comb begin
    step = STEP + ACC_W'({{(ACC_W-TRIM_W){i_trim[TRIM_W-1]}}, i_trim}) * ACC_W'(STEP >> 8);
    sum  = {1'b0, acc_r} + {1'b0, step};
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      acc_r  <= '0;
      o_tick <= 1'b0;
    end else begin
      acc_r  <= sum[ACC_W-1:0];
      o_tick <= sum[ACC_W];
    end
  end
endmodule // frc_tick_gen

/* File: design/flash_self_program_ctrl.sv */
/*
  flash_self_program_ctrl: run-time self-programming controller. cpu side is a
  strobe register port carrying control, unlock key and table accesses; array
  side is a command/address/data port with a busy handshake-free timer.
  assumes: i_nrst is power-on reset only; cpu honours o_cpu_stall.
*/
`timescale 1ns/100ps
// Overview of operation
// - table address is table page bits on top of the effective address
// - low table accesses hit program word bits 15:0, word or byte
// - high table accesses hit program word bits 23:16, word or byte
// - array rows hold 64 instructions, 192 bytes
// - erase takes one eight-row page; program takes one row or one word
// - pages align on 1536 bytes, rows on 192 bytes from address zero
// - 64-entry holding buffer filled in order from one aligned group
// - table write only changes the buffer, two instruction cycles
// - cpu stalls while an erase or program runs
// - operations timed in trimmed fast rc cycles, row write 11064
// - go bit starts operation, hardware clears it, software cannot clear
// - key register is 8-bit write-only, upper byte reads zero
// - enable bit zero blocks all program and erase operations
// - error flag set on improper attempt or early end; clear on success; only refused starts set it here
// - erase bit picks erase or program meaning of operation field
// - erase codes: bulk, general, secure segment, page, config byte
// - program codes: word, row, config byte; others do nothing
// - codes 1110 and 1011 reserved; unlisted codes unimplemented
// - control bits reset to zero on power-on reset only
// - control bits 12..7 and 5..4 read zero
module flash_self_program_ctrl
  import flash_spc_pkg::*;
#(
  parameter int unsigned ROW_CYC   = ROW_FRC_CYC,
  parameter int unsigned WORD_CYC  = 1550,
  parameter int unsigned PAGE_CYC  = 10285,
  parameter int unsigned BULK_CYC  = 40000,
  parameter int unsigned BUF_DEPTH = ROW_INSTR
) (
  input  wire logic              i_mclk,
  input  wire logic              i_nrst,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [17:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic [15:0]            o_rdata,
  output logic                   o_cpu_stall,
  output logic [2:0]             o_fl_cmd,
  output logic                   o_fl_start,
  output logic [23:0]            o_fl_addr,
  output logic [23:0]            o_fl_wdata,
  output logic [5:0]             o_fl_buf_idx,
  output logic                   o_fl_rd,
  input  wire logic [23:0]       i_fl_rdata
);
  // slot decode and alignment use fixed address bits, so geometry must match
  if (BUF_DEPTH != ROW_INSTR) begin : g_bad_depth
    $error("holding buffer must be one row");
  end
  if (ROW_CYC == 0 || WORD_CYC == 0 || PAGE_CYC == 0 || BULK_CYC == 0) begin : g_bad_timing
    $error("zero timing");
  end
  if (ROW_BYTES != ROW_INSTR * 3 || PAGE_BYTES != ROW_BYTES * PAGE_ROWS) begin : g_bad_geometry
    $error("row and page sizes disagree");
  end

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_DONE = 2'b11
  } state_e;

  // operation decode shared by start and timing paths
  function automatic fcmd_e decode_op(input logic erase, input logic [3:0] op);
    fcmd_e c;
    c = FCMD_NONE;
    if (erase) begin
      unique case (op)
        OP_BULK:   c = FCMD_BULK;
        OP_GENSEG: c = FCMD_SEG;
        OP_SECSEG: c = FCMD_SEG;
        OP_PAGE:   c = FCMD_PAGE;
        OP_CFG:    c = FCMD_CFGE;
        default:   c = FCMD_NONE;
      endcase
    end else begin
      unique case (op)
        OP_WORD:   c = FCMD_WORD;
        OP_ROW:    c = FCMD_ROW;
        OP_CFG:    c = FCMD_CFGP;
        default:   c = FCMD_NONE;
      endcase
    end
    return c;
  endfunction

  function automatic logic [31:0] op_cycles(input fcmd_e c);
    logic [31:0] n;
    n = 32'(WORD_CYC);
    unique case (c)
      FCMD_ROW:  n = 32'(ROW_CYC);
      FCMD_PAGE: n = 32'(PAGE_CYC);
      FCMD_BULK: n = 32'(BULK_CYC);
      FCMD_SEG:  n = 32'(BULK_CYC);
      default:   n = 32'(WORD_CYC);
    endcase
    return n;
  endfunction

  // register state
  logic              go_r;
  logic              en_r;
  logic              err_r;
  logic              erase_r;
  logic [3:0]        op_r;
  logic [7:0]        table_page_r;
  logic [15:0]       eff_addr_r;
  logic [TRIM_W-1:0] trim_r;
  logic              key1_r;
  logic              armed_r;
  state_e            state_r;
  fcmd_e             cmd_r;
  logic [31:0]       cnt_r;
  logic [5:0]        fill_r;
  logic [16:0]       group_r;
  logic              group_ok_r;
  logic              buf_busy_r;
  logic [23:0]       hold_mem [BUF_DEPTH];
  logic [15:0]       rdata_r;

  logic        wr_ctrl;
  logic        wr_key;
  logic        wr_low;
  logic        wr_high;
  logic        go_req;
  logic        start_ok;
  logic        frc_tick;
  logic [23:0] tbl_addr;
  logic [5:0]  slot;
  fcmd_e       dec_cmd;
  logic        op_launch;

  assign wr_ctrl  = i_wr && (i_addr == OFF_CTRL) && !o_cpu_stall;
  assign wr_key   = i_wr && (i_addr == OFF_KEY) && !o_cpu_stall;
  assign wr_low   = i_wr && (i_addr == OFF_TBL_LOW) && !o_cpu_stall;
  assign wr_high  = i_wr && (i_addr == OFF_TBL_HIGH) && !o_cpu_stall;
  assign tbl_addr = {table_page_r, eff_addr_r};
  assign slot     = eff_addr_r[6:1]; // two address units per instruction
  assign go_req   = wr_ctrl && i_wdata[CTL_GO] && !go_r;
  assign dec_cmd  = decode_op(i_wdata[CTL_ERASE], i_wdata[3:0]);
  // enable must already stand in the register; go and enable in one write is refused
  // row program also needs a full, single-group buffer
  assign start_ok = armed_r && en_r && i_wdata[CTL_EN] && (dec_cmd != FCMD_NONE)
                    && (dec_cmd != FCMD_ROW || (fill_r == 6'h3F && group_ok_r));
  assign o_cpu_stall = (state_r == ST_RUN) || buf_busy_r;
  assign op_launch   = (state_r == ST_IDLE) && go_req && start_ok;

  frc_tick_gen #(
    .ACC_W (16)
  ) u_frc (
    .i_mclk (i_mclk),
    .i_nrst (i_nrst),
    .i_trim (trim_r),
    .o_tick (frc_tick)
  );

  // unlock sequence: keys must be consecutive writes
  // reads leave the sequence alone; only accepted writes move it
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      key1_r  <= 1'b0;
      armed_r <= 1'b0;
    end else if (i_wr && !o_cpu_stall) begin
      key1_r  <= wr_key && (i_wdata[7:0] == KEY_FIRST);
      armed_r <= key1_r && wr_key && (i_wdata[7:0] == KEY_SECOND);
    end
  end

  // control register; only power-on reset clears it
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      {go_r, en_r, err_r, erase_r, op_r} <= 8'h00;
    end else begin
      if (wr_ctrl && !go_r) begin
        en_r    <= i_wdata[CTL_EN];
        erase_r <= i_wdata[CTL_ERASE];
        op_r    <= i_wdata[3:0];
        if (!i_wdata[CTL_ERR]) err_r <= 1'b0;
      end
      if (go_req) begin
        go_r  <= start_ok;
        err_r <= !start_ok; // set wins over clear
      end
      if (state_r == ST_DONE) begin
        go_r  <= 1'b0;
        err_r <= 1'b0;
      end
    end
  end

  // other software registers
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      table_page_r <= 8'h00;
      eff_addr_r   <= 16'h0000;
      trim_r       <= '0;
    end else if (i_wr && !o_cpu_stall) begin
      if (i_addr == OFF_TABLE_PAGE) table_page_r <= i_wdata[7:0];
      if (i_addr == OFF_EFF_ADDR) eff_addr_r <= i_wdata[15:0];
      if (i_addr == OFF_TRIM) trim_r <= i_wdata[TRIM_W-1:0];
    end
  end

  // holding buffer fill; writes take two cycles by stalling one
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      fill_r     <= 6'h00;
      group_r    <= 17'h00000;
      group_ok_r <= 1'b0;
      buf_busy_r <= 1'b0;
    end else begin
      buf_busy_r <= wr_low || wr_high;
      if (wr_high) begin
        fill_r <= slot; // sequential check by slot tracking
        // address bit 6 lies inside the row, so the group is bits 23:7
        if (slot == 6'h00) begin
          group_r    <= tbl_addr[23:7];
          group_ok_r <= 1'b1;
        end else if (tbl_addr[23:7] != group_r || slot != fill_r + 6'h01) begin
          group_ok_r <= 1'b0;
        end
      end
      if (state_r == ST_DONE) begin
        fill_r     <= 6'h00;
        group_ok_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (wr_low) begin
      if (i_wdata[TBL_BYTE_MODE]) begin
        if (i_wdata[TBL_BYTE_SEL]) hold_mem[slot][15:8] <= i_wdata[7:0];
        else hold_mem[slot][7:0] <= i_wdata[7:0];
      end else begin
        hold_mem[slot][15:0] <= i_wdata[15:0];
      end
    end
    if (wr_high && !(i_wdata[TBL_BYTE_MODE] && i_wdata[TBL_BYTE_SEL])) begin
      hold_mem[slot][23:16] <= i_wdata[7:0]; // phantom byte dropped
    end
  end

  // operation sequencer
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= ST_IDLE;
      cmd_r   <= FCMD_NONE;
      cnt_r   <= 32'h0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (op_launch) begin
            state_r <= ST_RUN;
            cmd_r   <= dec_cmd;
            cnt_r   <= op_cycles(dec_cmd);
          end
        end
        // run time follows the trim code because only fast rc ticks count
        ST_RUN: begin
          if (frc_tick) begin
            cnt_r <= cnt_r - 32'h1;
            if (cnt_r == 32'h1) state_r <= ST_DONE;
          end
        end
        ST_DONE: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // array side: command and aligned target, launched with the start pulse
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fl_cmd   <= 3'h0;
      o_fl_start <= 1'b0;
      o_fl_addr  <= 24'h0;
    end else begin
      o_fl_start <= op_launch;
      if (op_launch) begin
        o_fl_cmd <= dec_cmd;
        unique case (dec_cmd)
          FCMD_PAGE: o_fl_addr <= 24'(tbl_addr - tbl_addr % 24'(PAGE_BYTES / 3 * 2));
          FCMD_ROW:  o_fl_addr <= {tbl_addr[23:7], 7'h00};
          default:   o_fl_addr <= tbl_addr;
        endcase
      end
    end
  end

  // row words leave in step with their index so the array can pair them
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_fl_wdata   <= 24'h0;
      o_fl_buf_idx <= 6'h00;
    end else if (op_launch) begin
      o_fl_buf_idx <= 6'h00;
      o_fl_wdata   <= (dec_cmd == FCMD_ROW) ? hold_mem[6'h00] : hold_mem[slot];
    end else if ((state_r == ST_RUN) && (cmd_r == FCMD_ROW)) begin
      o_fl_buf_idx <= o_fl_buf_idx + 6'h01;
      o_fl_wdata   <= hold_mem[o_fl_buf_idx + 6'h01];
    end else begin
      o_fl_buf_idx <= 6'h00;
    end
  end

  assign o_fl_rd = i_rd && (i_addr == OFF_TBL_LOW || i_addr == OFF_TBL_HIGH);

  // read port; data one cycle later
  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_r <= 16'h0000;
    end else if (i_rd) begin
      unique case (i_addr)
        OFF_CTRL:       rdata_r <= {go_r, en_r, err_r, 6'h00, erase_r, 2'b00, op_r};
        OFF_KEY:        rdata_r <= 16'h0000;
        OFF_TABLE_PAGE: rdata_r <= {8'h00, table_page_r};
        OFF_EFF_ADDR:   rdata_r <= eff_addr_r;
        // table reads pass straight through; the array answers in the strobe cycle
        OFF_TBL_LOW:    rdata_r <= i_fl_rdata[15:0];
        OFF_TBL_HIGH:   rdata_r <= {8'h00, i_fl_rdata[23:16]};
        OFF_STATUS:     rdata_r <= {7'h00, armed_r, group_ok_r, 1'b0, fill_r};
        OFF_TRIM:       rdata_r <= {10'h000, trim_r};
        default:        rdata_r <= 16'h0000;
      endcase
    end
  end
  assign o_rdata = rdata_r;
endmodule // flash_self_program_ctrl

/* File: tb/flash_spc_checker.sv */
/*
  flash_spc_checker: port-level assertions for flash_self_program_ctrl.
  assumes: bound to the top module, one clock, async active-low reset.
*/
`timescale 1ns/100ps
module flash_spc_checker
  import flash_spc_pkg::*;
(
  input wire logic              i_mclk,
  input wire logic              i_nrst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [17:0]       i_wdata,
  input wire logic              i_wr,
  input wire logic              i_rd,
  input wire logic [15:0]       o_rdata,
  input wire logic              o_cpu_stall,
  input wire logic [2:0]        o_fl_cmd,
  input wire logic              o_fl_start,
  input wire logic [23:0]       o_fl_addr,
  input wire logic              o_fl_rd
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  sequence s_launch;
    o_fl_start ##1 o_cpu_stall;
  endsequence
  sequence s_ctrl_wr;
    i_wr && !o_cpu_stall && i_addr == OFF_CTRL;
  endsequence
  // test timer counts are at least 4 ticks, so 6 cycles is safe
  AST_START_STALL: assert property (o_fl_start |-> s_launch ##1 o_cpu_stall [*6])
    else $error("stall not held after start");
  AST_START_SOLO: assert property (o_fl_start |=> !o_fl_start)
    else $error("start longer than one cycle");
  AST_NO_EN: assert property (s_ctrl_wr ##0 (i_wdata[15] && !i_wdata[14]) |=> !o_fl_start [*3])
    else $error("start with enable low");
  AST_CMD: assert property (o_fl_start |-> o_fl_cmd != FCMD_NONE)
    else $error("start with empty command");
  AST_PAGE_ALIGN: assert property (o_fl_start && o_fl_cmd == FCMD_PAGE |-> o_fl_addr[9:0] == 10'h000)
    else $error("page address not aligned");
  AST_ROW_ALIGN: assert property (o_fl_start && o_fl_cmd == FCMD_ROW |-> o_fl_addr[6:0] == 7'h00)
    else $error("row address not aligned");
  AST_TBL_STALL: assert property (i_wr && !o_cpu_stall && (i_addr == OFF_TBL_LOW || i_addr == OFF_TBL_HIGH)
    |=> o_cpu_stall ##1 !o_cpu_stall)
    else $error("table write not two cycles");
  AST_KEY_RD: assert property (i_rd && i_addr == OFF_KEY |=> o_rdata == 16'h0000)
    else $error("key register readable");
  AST_CTRL_RD: assert property (i_rd && i_addr == OFF_CTRL |=> (o_rdata & ~CTL_IMPL_MASK) == 16'h0000)
    else $error("unimplemented control bits set");
  AST_HIGH_RD: assert property (i_rd && i_addr == OFF_TBL_HIGH |=> o_rdata[15:8] == 8'h00)
    else $error("high read upper byte set");
  AST_FL_RD: assert property (i_rd && !o_cpu_stall && i_addr == OFF_TBL_LOW |-> o_fl_rd)
    else $error("low read not sent to array");
endmodule // flash_spc_checker

bind flash_self_program_ctrl flash_spc_checker u_chk (
  .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_cpu_stall(o_cpu_stall), .o_fl_cmd(o_fl_cmd), .o_fl_start(o_fl_start),
  .o_fl_addr(o_fl_addr), .o_fl_rd(o_fl_rd)
);

/* File: tb/flash_array_model.sv */
/*
  flash_array_model: program flash array answering table reads.
  assumes: read data sampled in the same cycle as the read request.
*/
`timescale 1ns/100ps
module flash_array_model
(
  input  wire logic   i_fl_rd,
  output logic [23:0] o_fl_rdata
);
  localparam logic [23:0] WORD_PAT = 24'h5A3C96;
  // off-read the bus shows the inverse so stale data cannot pass
  assign o_fl_rdata = i_fl_rd ? WORD_PAT : ~WORD_PAT;
endmodule // flash_array_model

/* File: tb/flash_self_program_ctrl_test.sv */
/*
  flash_self_program_ctrl_test: register-port sequences with expected values.
  assumes: short timer parameters; array model on the flash side.
*/
`timescale 1ns/100ps
module flash_self_program_ctrl_test
  import flash_spc_pkg::*;
;
  logic        i_mclk = 1'b0;
  logic        i_nrst = 1'b0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [3:0]  i_addr = 4'h0;
  logic [17:0] i_wdata = 18'h00000;
  logic [15:0] o_rdata;
  logic        o_cpu_stall;
  logic [2:0]  o_fl_cmd;
  logic        o_fl_start;
  logic [23:0] o_fl_addr;
  logic [23:0] o_fl_wdata;
  logic [5:0]  o_fl_buf_idx;
  logic        o_fl_rd;
  logic [23:0] fl_rdata;
  logic [2:0]  last_cmd;
  logic [23:0] last_addr;
  logic [23:0] last_wdata;
  logic [23:0] row_word;
  logic [15:0] d;
  int          err_count = 0;
  int          check_count = 0;
  int          start_cnt = 0;
  // {erase, op, expected command}; zero command means nothing starts
  localparam logic [7:0] OPS [17] = '{8'hF9, 8'hEA, 8'hE2, 8'h93, 8'h84, 8'h98, 8'h88, 8'hF0, 8'hD8,
                                      8'h1D, 8'h07, 8'h78, 8'h68, 8'h60, 8'h10, 8'h70, 8'h58};
  always #10 i_mclk = ~i_mclk;
  flash_self_program_ctrl #(.ROW_CYC(4), .WORD_CYC(4), .PAGE_CYC(4), .BULK_CYC(4), .BUF_DEPTH(64)) dut (
    .i_mclk(i_mclk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_cpu_stall(o_cpu_stall), .o_fl_cmd(o_fl_cmd), .o_fl_start(o_fl_start),
    .o_fl_addr(o_fl_addr), .o_fl_wdata(o_fl_wdata), .o_fl_buf_idx(o_fl_buf_idx), .o_fl_rd(o_fl_rd),
    .i_fl_rdata(fl_rdata));
  flash_array_model u_fl (.i_fl_rd(o_fl_rd), .o_fl_rdata(fl_rdata));
  always @(posedge i_mclk) begin
    if (o_fl_start === 1'b1) begin
      start_cnt++;
      last_cmd = o_fl_cmd;
      last_addr = o_fl_addr;
      last_wdata = o_fl_wdata;
    end
    if (o_fl_buf_idx === 6'h05) row_word = o_fl_wdata;
  end
  task end_of_test;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input string n, input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task idle;
    int k;
    k = 0;
    while (o_cpu_stall !== 1'b0 && k < 2000) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    if (k == 2000) chk("stall_release", 24'h000000, {23'h0, o_cpu_stall});
  endtask
  task wr(input logic [3:0] a, input logic [17:0] v);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
    idle;
  endtask
  task rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask
  task rchk(input string n, input logic [3:0] a, input logic [15:0] e);
    rd(a, d);
    chk(n, {8'h00, e}, {8'h00, d});
  endtask
  // settle on the stall release, not a fixed wait: timer runs on trimmed ticks
  task launch(input logic [15:0] c);
    wr(OFF_CTRL, {2'b00, c});
    repeat (3) @(posedge i_mclk);
    #1;
    idle;
  endtask
  task go(input logic [15:0] c);
    wr(OFF_KEY, 18'h00055);
    wr(OFF_KEY, 18'h000AA);
    launch(c);
  endtask
  initial begin
    int s;
    repeat (20) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rchk("ctrl_reset", OFF_CTRL, 16'h0000);
    rchk("key_read", OFF_KEY, 16'h0000);
    wr(OFF_TABLE_PAGE, 18'h00001);
    wr(OFF_EFF_ADDR, 18'h00800);
    rchk("tbl_low", OFF_TBL_LOW, 16'h3C96);
    rchk("tbl_high", OFF_TBL_HIGH, 16'h005A);
    s = start_cnt;
    launch(16'hC042);
    chk("no_key_start", 24'(s), 24'(start_cnt));
    rchk("no_key_err", OFF_CTRL, 16'h6042);
    wr(OFF_KEY, 18'h00055);
    wr(OFF_TRIM, 18'h00000);
    wr(OFF_KEY, 18'h000AA);
    launch(16'hC042);
    chk("split_key_start", 24'(s), 24'(start_cnt));
    go(16'h8042);
    chk("no_en_start", 24'(s), 24'(start_cnt));
    rchk("no_en_err", OFF_CTRL, 16'h2042);
    wr(OFF_CTRL, 18'h04042);
    wr(OFF_KEY, 18'h00055);
    rchk("key_pending", OFF_STATUS, 16'h0000);
    wr(OFF_KEY, 18'h000AA);
    rchk("key_armed", OFF_STATUS, 16'h0100);
    launch(16'hC042);
    chk("page_starts", 24'(s + 1), 24'(start_cnt));
    chk("page_cmd", {21'h0, FCMD_PAGE}, {21'h0, last_cmd});
    chk("page_addr", 24'h010800, last_addr);
    rchk("page_done", OFF_CTRL, 16'h4042);
    for (int i = 0; i < 17; i++) begin
      s = start_cnt;
      go({2'b11, 7'h00, OPS[i][7], 2'b00, OPS[i][6:3]});
      chk("op_starts", 24'(s + int'(OPS[i][2:0] != 3'h0)), 24'(start_cnt));
      if (OPS[i][2:0] != 3'h0)
        chk("op_cmd", {21'h0, OPS[i][2:0]}, {21'h0, last_cmd});
    end
    for (int i = 0; i < 64; i++) begin
      wr(OFF_EFF_ADDR, {2'b00, 16'h0800 + 16'(2 * i)});
      wr(OFF_TBL_LOW, {2'b00, 16'(i * 257)});
      wr(OFF_TBL_HIGH, {10'h000, 8'(i)});
    end
    rchk("row_fill", OFF_STATUS, 16'h00BF);
    go(16'hC001);
    chk("row_cmd", {21'h0, FCMD_ROW}, {21'h0, last_cmd});
    chk("row_addr", 24'h010800, last_addr);
    chk("row_stream", 24'h050505, row_word);
    rchk("row_done", OFF_CTRL, 16'h4001);
    wr(OFF_TBL_LOW, 18'h100AB);
    wr(OFF_TBL_HIGH, 18'h300CD);
    go(16'hC003);
    chk("word_data", 24'h3F3FAB, last_wdata);
    @(posedge i_mclk);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_nrst <= 1'b1;
    rchk("ctrl_por", OFF_CTRL, 16'h0000);
    end_of_test;
  end
  // whole run is about a thousand cycles; ten thousand means a hang
  initial begin
    #200000;
    err_count++;
    end_of_test;
  end
endmodule // flash_self_program_ctrl_test
